// [efs_defs.vh]
// Constants for the parallel port FIFO service block
`ifndef EFS_DEFS_VH
`define EFS_DEFS_VH
// ----------------------------------------------------------------
// Port modes
// ----------------------------------------------------------------
`define EFS_MODE_STD    3'h0
`define EFS_MODE_BIDIR  3'h1
`define EFS_MODE_FIFO   3'h2
`define EFS_MODE_ECP    3'h3
`define EFS_MODE_RSVD   3'h5
`define EFS_MODE_TEST   3'h6
`define EFS_MODE_CFG    3'h7
// ----------------------------------------------------------------
// Control bit positions and host offsets
// ----------------------------------------------------------------
`define EFS_ECR_DMA_ENABLE_BIT_BIT 3
`define EFS_ECR_MASK_BIT  2
`define EFS_OFS_DATA      11'h0400
`define EFS_OFS_ADDR      11'h0000
// ----------------------------------------------------------------
// FIFO and timing
// ----------------------------------------------------------------
`define EFS_FIFO_DEPTH    5'h10
`define EFS_FIFO_AW       4
`define EFS_BURST_MAX     6'h20
`define EFS_CLK_NS        20
`define EFS_DACK_GAP_NS   350
`define EFS_DACK_GAP_CYC  ((`EFS_DACK_GAP_NS + `EFS_CLK_NS - 1) / `EFS_CLK_NS)
`define EFS_IRQ_PULSE_CYC 4'h4
`define EFS_RLE_MAX       7'h7F
`endif

// [efs_dma_host.sv]
// Behavioural host DMA controller facing the service block
`timescale 1ns/1ps
module efs_dma_host (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       port_dma_request,
  input  wire       dmaGo,
  input  wire [7:0] tcCount,
  input  wire [3:0] gap,
  output reg        port_dma_ack_n,
  output reg        dmaTc,
  output reg  [7:0] moved
);
  // One byte per sampled request; the gap lets a late request drop settle first
  initial begin
    port_dma_ack_n = 1'b1;
    dmaTc          = 1'b0;
    moved          = 8'h00;
    forever begin
      @(posedge clk_sys);
      if (reset) begin
        moved <= 8'h00;
      end else if (dmaGo && port_dma_request === 1'b1 && moved != tcCount) begin
        port_dma_ack_n <= 1'b0;
        dmaTc          <= (moved == tcCount - 8'h01);
        moved          <= moved + 8'h01;
        @(posedge clk_sys);
        port_dma_ack_n <= 1'b1;
        repeat (gap) @(posedge clk_sys);
        dmaTc <= 1'b0;
      end
    end
  end
endmodule

// [efs_fifo_mem.v]
// Sixteen-byte storage for the port FIFO, registered read data
`timescale 1ns/1ps
`include "efs_defs.vh"
module efs_fifo_mem (
  input  wire                   clk_sys,
  input  wire                   wrEn,
  input  wire [`EFS_FIFO_AW-1:0] wrAddr,
  input  wire [7:0]             wrData,
  input  wire [`EFS_FIFO_AW-1:0] rdAddr,
  output reg  [7:0]             rdData
);
  reg [7:0] mem [0:15];
  // ----------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// [efs_irq_pulse.v]
// Short low pulse on the shared interrupt line, then release
`timescale 1ns/1ps
`include "efs_defs.vh"
module efs_irq_pulse (
  input  wire clk_sys,
  input  wire reset,
  input  wire fire,
  output reg  irqOut,
  output reg  irqOe
);
  reg [3:0] cnt;
  // ----------------------------------------------------------------
  // Pulse timer; irqOe low means the line is driven
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      cnt   <= 4'h0;
      irqOe <= 1'b1;
    end else if (fire && cnt == 4'h0) begin
      cnt   <= `EFS_IRQ_PULSE_CYC;
      irqOe <= 1'b0;
    end else if (cnt != 4'h0) begin
      cnt   <= cnt - 4'h1;
      irqOe <= (cnt == 4'h1);
    end
  end
  // Always drive low when enabled; release is done through irqOe
  always @(posedge clk_sys) begin
    irqOut <= 1'b0;
  end
endmodule

// [efs_service.v]
// FIFO service logic: RLE expansion, DMA request pacing, interrupts
//
// Functional notes
// - Run-length count N repeats next byte N+1 times.
// - Control lines open-collector in mode 000 only.
// - Mask set blocks DMA and service interrupts.
// - Clearing mask with condition true interrupts immediately.
// - Interrupt pulses line low, then releases it.
// - Terminal count under DMA interrupts and sets mask.
// - Forward PIO interrupts when free space reaches trigger.
// - Reverse PIO interrupts when fill reaches trigger.
// - Threshold is field plus one; 16 acts as 15.
// - Error interrupt on fault fall, or on enable fall while fault is low.
// - Ack interrupt on rising acknowledge when enabled.
// - FIFO disabled after reset; only FIFO/ECP/test/config modes.
// - DMA acknowledge accesses FIFO regardless of address.
// - Request limited to 32 cycles, then 350ns gap.
// - Reverse DMA requests while FIFO holds data.
// - Last byte drops request on ack or read.
// - Re-request after empty; after TC wait mask clear.
// - Data/test FIFO at 400H, address FIFO at 000H.
// - DMA moves single bytes, ends only on TC.
// - Mode field encodes port modes; 101 reserved.
// - DMA enable bit 3, service mask bit 2.
`timescale 1ns/1ps
`include "efs_defs.vh"
module efs_service (
  input  wire        clk_sys,
  input  wire        reset,
  // Control register image
  input  wire [2:0]  portMode,
  input  wire        direction,
  input  wire [3:0]  fifo_threshold_field,
  input  wire [7:0]  ecrWrData,
  input  wire        ecrWrite,
  input  wire        error_irq_enable_n,
  input  wire        ack_irq_enable,
  // Host programmed I/O
  input  wire [10:0] hostAddr,
  input  wire        hostWr,
  input  wire        hostRd,
  input  wire [7:0]  hostWrData,
  // Host DMA
  input  wire        port_dma_ack_n,
  input  wire        dmaTc,
  // Peripheral side byte stream
  input  wire        periphValid,
  input  wire        periphIsCmd,
  input  wire [7:0]  periphData,
  input  wire        periphPop,
  // Status pins
  input  wire        nFault,
  input  wire        nAck,
  // Outputs
  output reg  [7:0]  hostRdData,
  output reg         dma_enable_bit,
  output reg         service_irq_mask,
  output reg         fifoFull,
  output reg         fifoEmpty,
  output reg         periphReady,
  output reg  [7:0]  periphOutData,
  output reg         periphOutIsCmd,
  output reg         port_dma_request,
  output wire        port_irq_line,
  output wire        port_irq_oe,
  output reg         ctlPushPull
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function fifoMode;
    input [2:0] m;
    begin
      // Reserved and EPP codes keep the FIFO held empty
      fifoMode = (m == `EFS_MODE_FIFO) || (m == `EFS_MODE_ECP) ||
                 (m == `EFS_MODE_TEST) || (m == `EFS_MODE_CFG);
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers for pins
  // ----------------------------------------------------------------
  reg [1:0] dackSync;
  reg [1:0] faultSync;
  reg [1:0] ackSync;
  reg       faultPrev;
  reg       ackPrev;
  reg       errEnPrev;
  always @(posedge clk_sys) begin
    if (reset) begin
      dackSync  <= 2'b11;
      faultSync <= 2'b11;
      ackSync   <= 2'b11;
      faultPrev <= 1'b1;
      ackPrev   <= 1'b1;
      errEnPrev <= 1'b1;
    end else begin
      dackSync  <= {dackSync[0], port_dma_ack_n};
      faultSync <= {faultSync[0], nFault};
      ackSync   <= {ackSync[0], nAck};
      faultPrev <= faultSync[1];
      ackPrev   <= ackSync[1];
      errEnPrev <= error_irq_enable_n;
    end
  end
  wire dackOn = ~dackSync[1];

  // ----------------------------------------------------------------
  // FIFO pointers and occupancy
  // ----------------------------------------------------------------
  reg  [3:0] wrPtr;
  reg  [3:0] rdPtr;
  reg  [4:0] count;
  wire       fifoOn = fifoMode(portMode);
  wire       hostData = (hostAddr == `EFS_OFS_DATA);
  wire       hostAddrF = (hostAddr == `EFS_OFS_ADDR) && !direction;
  wire       dmaXfer = dackOn && dma_enable_bit;
  // Forward: host or DMA fills, peripheral drains; reverse swaps roles
  wire       hostPush = !direction && (hostWr && (hostData || hostAddrF) || dmaXfer);
  wire       hostPop  = direction && (hostRd && hostData || dmaXfer);
  reg        rlePush;
  wire       push = fifoOn && count != `EFS_FIFO_DEPTH &&
                    (hostPush || rlePush);
  wire       pop  = fifoOn && count != 5'h00 &&
                    (hostPop || (!direction && periphPop));
  reg  [7:0] pushData;
  wire [7:0] memRd;
  reg        cmdTag [0:15];

  efs_fifo_mem uMem (
    .clk_sys (clk_sys),
    .wrEn    (push),
    .wrAddr  (wrPtr),
    .wrData  (pushData),
    .rdAddr  (push || pop ? rdPtr + {3'h0, pop} : rdPtr),
    .rdData  (memRd)
  );

  // ----------------------------------------------------------------
  // RLE expansion on reverse data; a count holds the next byte
  // ----------------------------------------------------------------
  reg  [6:0] rleLeft;
  reg  [7:0] rleByte;
  reg        rleArmed;
  reg        rleBusy;
  always @* begin
    rlePush  = direction && (rleBusy || periphValid && !periphIsCmd);
    pushData = direction ? (rleBusy ? rleByte : periphData) : hostWrData;
  end
  always @(posedge clk_sys) begin
    if (reset || !fifoOn) begin
      rleLeft  <= 7'h00;
      rleByte  <= 8'h00;
      rleArmed <= 1'b0;
      rleBusy  <= 1'b0;
    end else if (rleBusy) begin
      if (push) begin
        rleLeft <= rleLeft - 7'h01;
        rleBusy <= (rleLeft != 7'h00);
      end
    end else if (direction && periphValid && periphIsCmd && !periphData[7]) begin
      rleLeft  <= periphData[6:0];
      rleArmed <= 1'b1;
    end else if (rleArmed && periphValid && push) begin
      // First copy stored now; count more remain
      rleByte  <= periphData;
      rleArmed <= 1'b0;
      rleBusy  <= (rleLeft != 7'h00);
      rleLeft  <= rleLeft - 7'h01;
    end
  end
  always @* begin
    periphReady = direction ? (!rleBusy && count != `EFS_FIFO_DEPTH) : 1'b0;
  end

  // ----------------------------------------------------------------
  // Pointers, tags and flags
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset || !fifoOn) begin
      wrPtr <= 4'h0;
      rdPtr <= 4'h0;
      count <= 5'h00;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 4'h1;
        cmdTag[wrPtr] <= !direction && hostWr && hostAddrF;
      end
      if (pop) begin
        rdPtr <= rdPtr + 4'h1;
      end
      count <= count + {4'h0, push} - {4'h0, pop};
    end
  end
  always @(posedge clk_sys) begin
    if (reset) begin
      fifoFull       <= 1'b0;
      fifoEmpty      <= 1'b1;
      hostRdData     <= 8'h00;
      periphOutData  <= 8'h00;
      periphOutIsCmd <= 1'b0;
      ctlPushPull    <= 1'b0;
    end else begin
      fifoFull       <= (count == `EFS_FIFO_DEPTH);
      fifoEmpty      <= (count == 5'h00);
      hostRdData     <= memRd;
      periphOutData  <= memRd;
      periphOutIsCmd <= cmdTag[rdPtr];
      ctlPushPull    <= (portMode != `EFS_MODE_STD);
    end
  end

  // ----------------------------------------------------------------
  // Thresholds: trigger = 16 - (field + 1), 16 clamps to 15
  // ----------------------------------------------------------------
  wire [4:0] thrEff  = {1'b0, fifo_threshold_field} + 5'h01;
  wire [4:0] thrUse  = (thrEff == 5'h10) ? 5'h0F : thrEff;
  wire [4:0] free_space_trigger = `EFS_FIFO_DEPTH - thrUse;
  wire [4:0] fill_level_trigger = `EFS_FIFO_DEPTH - thrUse;
  wire [4:0] freeBytes = `EFS_FIFO_DEPTH - count;
  wire       pioCond = !dma_enable_bit && fifoOn &&
                       (direction ? count >= fill_level_trigger
                                  : freeBytes >= free_space_trigger);

  // ----------------------------------------------------------------
  // Control register bits; hardware set beats software clear
  // ----------------------------------------------------------------
  reg  tcSeen;
  wire tcHit = dmaTc && dackOn && dma_enable_bit && !service_irq_mask;
  wire pioHit = pioCond && !service_irq_mask;
  always @(posedge clk_sys) begin
    if (reset) begin
      dma_enable_bit   <= 1'b0;
      service_irq_mask <= 1'b1;
    end else begin
      if (ecrWrite) begin
        dma_enable_bit   <= ecrWrData[`EFS_ECR_DMA_ENABLE_BIT_BIT];
        service_irq_mask <= ecrWrData[`EFS_ECR_MASK_BIT];
      end
      if (tcHit || pioHit) begin
        service_irq_mask <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // DMA request pacing: burst limit, gap after ack, TC latch
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_REQ  = 3'b010;
  localparam ST_GAP  = 3'b100;
  reg [2:0] state;
  reg [5:0] burst;
  reg [4:0] gapCnt;
  reg       dackPrev;
  wire      dmaGo = dma_enable_bit && !service_irq_mask && fifoOn && !tcSeen;
  wire      wantReq = direction ? (count > 5'h01 || count == 5'h01 && !dmaXfer)
                                : (count < `EFS_FIFO_DEPTH - 5'h01);
  wire      ackRise = dackOn && !dackPrev;
  always @(posedge clk_sys) begin
    if (reset) begin
      state            <= ST_IDLE;
      burst            <= 6'h00;
      gapCnt           <= 5'h00;
      dackPrev         <= 1'b0;
      tcSeen           <= 1'b0;
      port_dma_request <= 1'b0;
    end else begin
      dackPrev <= dackOn;
      if (tcHit) begin
        tcSeen <= 1'b1;
      end else if (ecrWrite && !ecrWrData[`EFS_ECR_MASK_BIT]) begin
        tcSeen <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          burst <= 6'h00;
          if (dmaGo && wantReq) begin
            state            <= ST_REQ;
            port_dma_request <= 1'b1;
          end else begin
            port_dma_request <= 1'b0;
          end
        end
        ST_REQ: begin
          if (ackRise) begin
            burst <= burst + 6'h01;
          end
          if (!dmaGo || tcHit || !wantReq) begin
            state            <= ST_IDLE;
            port_dma_request <= 1'b0;
          end else if (ackRise && burst == `EFS_BURST_MAX - 6'h01) begin
            state            <= ST_GAP;
            port_dma_request <= 1'b0;
            gapCnt           <= 5'h00;
          end
        end
        ST_GAP: begin
          port_dma_request <= 1'b0;
          if (dackOn) begin
            gapCnt <= 5'h00;
          end else if (gapCnt == `EFS_DACK_GAP_CYC) begin
            state <= ST_IDLE;
          end else begin
            gapCnt <= gapCnt + 5'h01;
          end
        end
        default: begin
          state            <= ST_IDLE;
          port_dma_request <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Error and acknowledge interrupt events
  // ----------------------------------------------------------------
  wire errHit = !error_irq_enable_n &&
                ((faultPrev && !faultSync[1]) ||
                 (errEnPrev && !faultSync[1]));
  wire ackHit = ack_irq_enable && !ackPrev && ackSync[1];
  reg  irqFire;
  always @(posedge clk_sys) begin
    if (reset) begin
      irqFire <= 1'b0;
    end else begin
      irqFire <= tcHit || pioHit || errHit || ackHit;
    end
  end

  efs_irq_pulse uIrq (
    .clk_sys (clk_sys),
    .reset   (reset),
    .fire    (irqFire),
    .irqOut  (port_irq_line),
    .irqOe   (port_irq_oe)
  );
endmodule

// [efs_service_chk.sv]
// Concurrent checks on the ports of the FIFO service block
`timescale 1ns/1ps
`include "efs_defs.vh"
module efs_service_chk (
  input wire       clk_sys,
  input wire       reset,
  input wire [2:0] portMode,
  input wire       error_irq_enable_n,
  input wire       ack_irq_enable,
  input wire       port_dma_ack_n,
  input wire       dmaTc,
  input wire       nFault,
  input wire       nAck,
  input wire       dma_enable_bit,
  input wire       service_irq_mask,
  input wire       fifoEmpty,
  input wire       port_dma_request,
  input wire       port_irq_line,
  input wire       port_irq_oe,
  input wire       ctlPushPull
);
  reg [5:0] burst;
  reg [5:0] ackHigh;
  reg       capped;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Request burst bookkeeping
  // ----------------------------------------------------------------
  // Capped stays set until the ack has idled long enough to free the bus
  always @(posedge clk_sys) begin
    if (reset) begin
      burst   <= 6'h00;
      ackHigh <= 6'h00;
      capped  <= 1'b0;
    end else begin
      ackHigh <= !port_dma_ack_n ? 6'h00 : (ackHigh == 6'h3F ? ackHigh : ackHigh + 6'h01);
      burst   <= !port_dma_request ? 6'h00 : burst + {5'h00, $rose(port_dma_ack_n)};
      capped  <= (burst == 6'h20) | (capped & (ackHigh < 6'h11));
    end
  end
  sequence s_pulse;
    (!port_irq_oe)[*4] ##1 port_irq_oe;
  endsequence
  sequence s_fire;
    ##[1:6] !port_irq_oe;
  endsequence
  chk_pulse_shape: assert property ($fell(port_irq_oe) |-> s_pulse)
    else $error("irq pulse has wrong length");
  chk_line_low: assert property (!port_irq_oe |-> !port_irq_line)
    else $error("irq line driven high");
  chk_ack_irq: assert property (ack_irq_enable && $rose(nAck) && port_irq_oe |-> s_fire)
    else $error("no irq after ack rise");
  chk_fault_irq: assert property (!error_irq_enable_n && $fell(nFault) && port_irq_oe |-> s_fire)
    else $error("no irq after fault fall");
  chk_tc_mask: assert property (dma_enable_bit && !service_irq_mask && dmaTc && !port_dma_ack_n
    |-> ##[1:6] service_irq_mask)
    else $error("mask not set on terminal count");
  chk_mask_blocks: assert property ((service_irq_mask)[*4] |-> !port_dma_request)
    else $error("request while masked");
  chk_dma_off: assert property ((!dma_enable_bit)[*4] |-> !port_dma_request)
    else $error("request while dma disabled");
  chk_burst_cap: assert property (port_dma_request |-> burst <= 6'h20)
    else $error("request held beyond burst limit");
  chk_gap_hold: assert property ($rose(port_dma_request) |-> !capped)
    else $error("request before ack idle gap");
  chk_ctl_drive: assert property (!$past(reset) && $stable(portMode)
    |-> ctlPushPull == (portMode != `EFS_MODE_STD))
    else $error("control driver style wrong");
  chk_fifo_off: assert property ((portMode == `EFS_MODE_STD)[*3] |-> fifoEmpty)
    else $error("fifo not empty in standard mode");
endmodule
bind efs_service efs_service_chk chk_u (
  .clk_sys(clk_sys), .reset(reset), .portMode(portMode),
  .error_irq_enable_n(error_irq_enable_n), .ack_irq_enable(ack_irq_enable),
  .port_dma_ack_n(port_dma_ack_n), .dmaTc(dmaTc), .nFault(nFault), .nAck(nAck),
  .dma_enable_bit(dma_enable_bit), .service_irq_mask(service_irq_mask),
  .fifoEmpty(fifoEmpty), .port_dma_request(port_dma_request),
  .port_irq_line(port_irq_line), .port_irq_oe(port_irq_oe), .ctlPushPull(ctlPushPull));

// [tb_top.sv]
// Self-checking bench for the FIFO service block
`timescale 1ns/1ps
`include "efs_defs.vh"
module tb_top;
  reg         clk_sys, reset, direction, ecrWrite, hostWr, hostRd, dmaGo;
  reg         error_irq_enable_n, ack_irq_enable, periphValid, periphIsCmd, periphPop;
  reg         nFault, nAck;
  reg  [2:0]  portMode;
  reg  [3:0]  fifo_threshold_field;
  reg  [7:0]  ecrWrData, hostWrData, periphData, cnt;
  reg  [10:0] hostAddr;
  wire        port_dma_ack_n, dmaTc, dma_enable_bit, service_irq_mask, fifoFull, fifoEmpty;
  wire        periphReady, periphOutIsCmd, port_dma_request, port_irq_line, port_irq_oe;
  wire        ctlPushPull;
  wire [7:0]  hostRdData, periphOutData, moved;
  integer     miscompares, n_compared, irqs, i, k, n, trig;
  efs_service dut_u (
    .clk_sys(clk_sys), .reset(reset), .portMode(portMode), .direction(direction),
    .fifo_threshold_field(fifo_threshold_field), .ecrWrData(ecrWrData), .ecrWrite(ecrWrite),
    .error_irq_enable_n(error_irq_enable_n), .ack_irq_enable(ack_irq_enable),
    .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd), .hostWrData(hostWrData),
    .port_dma_ack_n(port_dma_ack_n), .dmaTc(dmaTc), .periphValid(periphValid),
    .periphIsCmd(periphIsCmd), .periphData(periphData), .periphPop(periphPop),
    .nFault(nFault), .nAck(nAck), .hostRdData(hostRdData), .dma_enable_bit(dma_enable_bit),
    .service_irq_mask(service_irq_mask), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty),
    .periphReady(periphReady), .periphOutData(periphOutData),
    .periphOutIsCmd(periphOutIsCmd), .port_dma_request(port_dma_request),
    .port_irq_line(port_irq_line), .port_irq_oe(port_irq_oe), .ctlPushPull(ctlPushPull));
  efs_dma_host host_u (
    .clk_sys(clk_sys), .reset(reset), .port_dma_request(port_dma_request), .dmaGo(dmaGo),
    .tcCount(8'h28), .gap(4'h6), .port_dma_ack_n(port_dma_ack_n), .dmaTc(dmaTc),
    .moved(moved));
  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Every falling enable is one interrupt pulse
  always @(negedge port_irq_oe) irqs = irqs + 1;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input [8*10:1] nm, input [7:0] e, input [7:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task cmpb(input [8*10:1] nm, input e, input g);
    cmp(nm, {7'h00, e}, {7'h00, g});
  endtask
  // Outputs are read one step after the edge so their updates have landed
  task settle(input integer c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task setm(input [2:0] m, input d, input [3:0] f);
    @(posedge clk_sys);
    portMode             <= m;
    direction            <= d;
    fifo_threshold_field <= f;
  endtask
  task ecr(input en, input msk);
    @(posedge clk_sys);
    ecrWrData <= {4'h0, en, msk, 2'h0};
    ecrWrite  <= 1'b1;
    @(posedge clk_sys);
    ecrWrite  <= 1'b0;
  endtask
  task hwr(input [10:0] a, input [7:0] d);
    @(posedge clk_sys);
    hostAddr   <= a;
    hostWrData <= d;
    hostWr     <= 1'b1;
    @(posedge clk_sys);
    hostWr     <= 1'b0;
  endtask
  task hrd;
    @(posedge clk_sys);
    hostAddr <= `EFS_OFS_DATA;
    hostRd   <= 1'b1;
    @(posedge clk_sys);
    hostRd   <= 1'b0;
    settle(3);
  endtask
  task pop;
    @(posedge clk_sys);
    periphPop <= 1'b1;
    @(posedge clk_sys);
    periphPop <= 1'b0;
    settle(2);
  endtask
  // Ready is combinational, so it is looked at mid-cycle
  task psend(input c, input [7:0] d);
    integer w;
    w = 0;
    @(negedge clk_sys);
    while (periphReady !== 1'b1 && w < 64) begin
      @(negedge clk_sys);
      w = w + 1;
    end
    @(posedge clk_sys);
    periphValid <= 1'b1;
    periphIsCmd <= c;
    periphData  <= d;
    @(posedge clk_sys);
    periphValid <= 1'b0;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    $display("watchdog expired");
    stop_test;
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {reset, direction, ecrWrite, hostWr, hostRd, dmaGo} = 6'h20;
    {ack_irq_enable, periphValid, periphIsCmd, periphPop} = 4'h0;
    {nFault, nAck, error_irq_enable_n} = 3'h7;
    {portMode, fifo_threshold_field, ecrWrData, hostWrData, periphData, hostAddr} = 42'h0;
    {miscompares, n_compared, irqs} = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    settle(1);
    cmpb("mask", 1'b1, service_irq_mask);
    cmpb("dma_enable_bit", 1'b0, dma_enable_bit);
    cmpb("request", 1'b0, port_dma_request);
    cmpb("irqoe", 1'b1, port_irq_oe);
    cmpb("empty", 1'b1, fifoEmpty);
    cmpb("full", 1'b0, fifoFull);
    cmpb("ready", 1'b0, periphReady);
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      setm(i[2:0], 1'b0, 4'h3);
      settle(3);
      cmpb("pushpull", i != 0, ctlPushPull);
    end
    setm(`EFS_MODE_STD, 1'b0, 4'h3);
    hwr(`EFS_OFS_DATA, 8'h11);
    settle(3);
    cmpb("empty", 1'b1, fifoEmpty);
    $display("test modes done");
    setm(`EFS_MODE_ECP, 1'b0, 4'h3);
    irqs = 0;
    ecr(1'b0, 1'b0);
    settle(8);
    cmp("irqs", 8'h01, irqs[7:0]);
    hwr(`EFS_OFS_ADDR, 8'h05);
    for (i = 0; i < 15; i = i + 1) hwr(`EFS_OFS_DATA, 8'h10 + i[7:0]);
    settle(2);
    cmpb("full", 1'b1, fifoFull);
    ecr(1'b0, 1'b0);
    settle(8);
    cmp("irqs", 8'h01, irqs[7:0]);
    cmpb("outcmd", 1'b1, periphOutIsCmd);
    cmp("outdata", 8'h05, periphOutData);
    pop;
    cmpb("outcmd", 1'b0, periphOutIsCmd);
    cmp("outdata", 8'h10, periphOutData);
    for (i = 1; i < 11; i = i + 1) pop;
    settle(6);
    cmp("irqs", 8'h01, irqs[7:0]);
    pop;
    settle(6);
    cmp("irqs", 8'h02, irqs[7:0]);
    for (i = 0; i < 4; i = i + 1) pop;
    cmpb("empty", 1'b1, fifoEmpty);
    $display("test forward done");
    for (k = 0; k < 2; k = k + 1) begin
      trig = k ? 1 : 15;
      setm(`EFS_MODE_BIDIR, 1'b1, k ? 4'hF : 4'h0);
      setm(`EFS_MODE_ECP, 1'b1, k ? 4'hF : 4'h0);
      irqs = 0;
      for (i = 0; i < trig - 1; i = i + 1) psend(1'b0, i[7:0]);
      ecr(1'b0, 1'b0);
      settle(8);
      cmp("irqs", 8'h00, irqs[7:0]);
      psend(1'b0, 8'hEE);
      settle(8);
      cmp("irqs", 8'h01, irqs[7:0]);
      for (i = 0; i < trig; i = i + 1) hrd;
      cmpb("empty", 1'b1, fifoEmpty);
    end
    $display("test reverse done");
    for (k = 0; k < 2; k = k + 1) begin
      cnt = k ? `EFS_RLE_MAX : 8'h00;
      psend(1'b1, cnt);
      psend(1'b0, 8'hA5);
      settle(4);
      n = 0;
      for (i = 0; i < 400 && n < 200; i = i + 1) begin
        if (fifoEmpty === 1'b0) begin
          hrd;
          n = n + 1;
          if (fifoEmpty === 1'b0) cmp("rledata", 8'hA5, hostRdData);
        end else settle(1);
      end
      cmp("rlecount", cnt + 8'h01, n[7:0]);
    end
    $display("test rle done");
    @(posedge clk_sys);
    dmaGo <= 1'b1;
    irqs = 0;
    ecr(1'b1, 1'b0);
    psend(1'b1, `EFS_RLE_MAX);
    psend(1'b0, 8'h5A);
    for (i = 0; i < 3000 && moved !== 8'h28; i = i + 1) settle(1);
    settle(10);
    cmp("moved", 8'h28, moved);
    cmpb("mask", 1'b1, service_irq_mask);
    cmp("irqs", 8'h01, irqs[7:0]);
    cmpb("request", 1'b0, port_dma_request);
    cmpb("empty", 1'b0, fifoEmpty);
    settle(30);
    cmpb("request", 1'b0, port_dma_request);
    ecr(1'b1, 1'b0);
    settle(6);
    cmpb("request", 1'b1, port_dma_request);
    ecr(1'b1, 1'b1);
    ecr(1'b0, 1'b1);
    settle(6);
    cmpb("request", 1'b0, port_dma_request);
    $display("test dma done");
    irqs = 0;
    @(posedge clk_sys);
    error_irq_enable_n <= 1'b0;
    settle(8);
    @(posedge clk_sys);
    nFault <= 1'b0;
    settle(10);
    cmp("irqs", 8'h01, irqs[7:0]);
    @(posedge clk_sys);
    error_irq_enable_n <= 1'b1;
    settle(4);
    @(posedge clk_sys);
    error_irq_enable_n <= 1'b0;
    settle(10);
    @(posedge clk_sys);
    nFault <= 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clk_sys);
      ack_irq_enable <= k[0];
      nAck           <= 1'b0;
      settle(4);
      @(posedge clk_sys);
      nAck <= 1'b1;
      settle(10);
      cmp("irqs", 8'h02 + k[7:0], irqs[7:0]);
    end
    $display("test status irq done");
    stop_test;
  end
endmodule
